// ---- verilog/mia_top.sv ----
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps
// What this block does
// RULE1: two software interrupts, raised by software pending bits one and zero.
// RULE2: software interrupt accepted no sooner than three cycles after pending; pc saved.
// RULE3: software interrupt needs its mask bit, global enable, no error or exception level.
// RULE4: hardware interrupt beats a software interrupt arriving in the same cycle.
// RULE5: software acceptance with shadows enabled copies current set to previous only.
// RULE6: writing trigger mode 01 to source zero control raises source zero.
// RULE7: maskable hardware sources, each with its own level out of seven.
// RULE8: hardware interrupt needs mask bits four to two, enable, no error/exception level.
// RULE9: highest level wins; equal levels go to lowest source number.
// RULE10: hardware acceptance sets exception level and loads mask level; enable unchanged.
// RULE11: hardware acceptance switches bank to set equal to level unless disabled.
// RULE12: after exception level cleared, only levels above current mask level accepted.
// RULE13: every hardware request from a source with a nonzero level triggers a dma transfer.
// RULE14: vector code is four times the source number.
// RULE15: sources 22 and 23 are motor emergency stops, vectors 0x058 and 0x05c.
// RULE16: source 33 is timer zero emergency, vector 0x084; 25 to 32 timers.
// RULE17: level zero sources never interrupt and are not latched.
// RULE18: repeated request before clearing is ignored.
// RULE19: mask level and vector held after acceptance until vector register read.
// RULE20: one pending flag per source, cleared by software; arbitrate pending only.
module mia_top #(
    parameter int NSRC = 96,
    parameter int IW   = 7
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            ce,
    input  wire logic [11:0]     s_axi_awaddr,
    input  wire logic            s_axi_awvalid,
    output logic                 s_axi_awready,
    input  wire logic [31:0]     s_axi_wdata,
    input  wire logic [3:0]      s_axi_wstrb,
    input  wire logic            s_axi_wvalid,
    output logic                 s_axi_wready,
    output logic [1:0]           s_axi_bresp,
    output logic                 s_axi_bvalid,
    input  wire logic            s_axi_bready,
    input  wire logic [11:0]     s_axi_araddr,
    input  wire logic            s_axi_arvalid,
    output logic                 s_axi_arready,
    output logic [31:0]          s_axi_rdata,
    output logic [1:0]           s_axi_rresp,
    output logic                 s_axi_rvalid,
    input  wire logic            s_axi_rready,
    input  wire logic [NSRC-1:0] irq_req,
    input  wire logic            motor0_count_match_int,
    input  wire logic            motor0_emergency_int,
    input  wire logic            motor1_emergency_int,
    input  wire logic            timer0_emergency_int,
    input  wire logic [31:0]     core_pc,
    output logic                 take_hw,
    output logic                 take_sw,
    output logic [3:0]           active_bank,
    output logic [NSRC-1:0]      dma_trigger
);
    logic [2:0]      lvl_reg [NSRC];
    logic [2:0]      lvl_next [NSRC];
    logic [NSRC-1:0] pend_reg, pend_next;
    logic [1:0]      src0_mode_reg, src0_mode_next;
    logic [31:0]     status_reg, status_next;
    logic [1:0]      soft_pending_bits_reg, soft_pending_bits_next;
    logic [1:0]      sw_age_reg [2];
    logic [1:0]      sw_age_next [2];
    logic            shadow_set_disable_reg, shadow_set_disable_next;
    logic [3:0]      current_shadow_set_reg, current_shadow_set_next;
    logic [3:0]      previous_shadow_set_reg, previous_shadow_set_next;
    logic [2:0]      current_mask_level_reg, current_mask_level_next;
    logic [8:0]      vector_register_reg, vector_register_next;
    logic            hold_reg, hold_next;
    logic [31:0]     exception_return_pc_reg, exception_return_pc_next;
    logic [NSRC-1:0] dma_reg, dma_next;
    logic            bvalid_reg, bvalid_next;
    logic [1:0]      bresp_reg, bresp_next;
    logic            rvalid_reg, rvalid_next;
    logic [1:0]      rresp_reg, rresp_next;
    logic [31:0]     rdata_reg, rdata_next;

    logic            wr_go, rd_go, vec_rd;
    logic [NSRC-1:0] req_all, zero_lvl;
    logic [IW-1:0]   best_idx;
    logic [2:0]      best_lvl;
    logic            best_found, hw_ok, sw_ok;
    logic [1:0]      sw_ready;
    logic            global_int_enable, exception_level_flag, error_level_flag;
    logic [4:0]      int_mask_bits;
    logic [IW-1:0]   wsrc, rsrc;

    assign global_int_enable    = status_reg[mia_pkg::ST_ENABLE];
    assign exception_level_flag = status_reg[mia_pkg::ST_EXC];
    assign error_level_flag     = status_reg[mia_pkg::ST_ERR];
    assign int_mask_bits        = status_reg[mia_pkg::ST_MASK +: 5];
    assign wsrc          = s_axi_awaddr[IW+1:2];
    assign rsrc          = s_axi_araddr[IW+1:2];

    // both channels must be present; taking them together keeps the write path single-cycle
    assign wr_go         = ce && s_axi_awvalid && s_axi_wvalid && !bvalid_reg;
    assign rd_go         = ce && s_axi_arvalid && !rvalid_reg;
    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_arready = rd_go;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rresp   = rresp_reg;
    assign s_axi_rdata   = rdata_reg;
    assign vec_rd        = rd_go && s_axi_araddr == mia_pkg::OFF_VECTOR;
    assign active_bank   = current_shadow_set_reg;
    assign dma_trigger   = dma_reg;

    always_comb begin
        req_all = irq_req;
        req_all[mia_pkg::SRC_MOTOR0_MATCH] = irq_req[mia_pkg::SRC_MOTOR0_MATCH] | motor0_count_match_int; // RULE14
        req_all[mia_pkg::SRC_MOTOR0_EMG] = irq_req[mia_pkg::SRC_MOTOR0_EMG] | motor0_emergency_int; // RULE15
        req_all[mia_pkg::SRC_MOTOR1_EMG] = irq_req[mia_pkg::SRC_MOTOR1_EMG] | motor1_emergency_int; // RULE15
        req_all[mia_pkg::SRC_TIMER0_EMG] = irq_req[mia_pkg::SRC_TIMER0_EMG] | timer0_emergency_int; // RULE16
        // software-set request on source zero
        if (wr_go && s_axi_awaddr[11:9] == mia_pkg::SRC_AREA && wsrc == '0
            && s_axi_wdata[mia_pkg::SC_TRIG +: 2] == mia_pkg::TRIG_SOFT_SET) begin
            req_all[0] = 1'b1; // RULE6
        end
    end

    // arbitration: descending scan with >= leaves the lowest number on a tie
    always_comb begin
        best_idx   = '0;
        best_lvl   = '0;
        best_found = 1'b0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            zero_lvl[i] = lvl_reg[i] == 3'h0;
            if (pend_reg[i] && lvl_reg[i] > current_mask_level_reg && lvl_reg[i] >= best_lvl) begin // RULE12 RULE20
                best_idx   = IW'(i); // RULE9
                best_lvl   = lvl_reg[i];
                best_found = 1'b1;
            end
        end
    end

    always_comb begin
        for (int b = 0; b < 2; b++) begin
            sw_ready[b] = soft_pending_bits_reg[b] && int_mask_bits[b]
                          && sw_age_reg[b] == mia_pkg::SW_MIN_AGE; // RULE2 RULE3
        end
    end

    assign hw_ok   = best_found && !hold_reg && int_mask_bits[4:2] == mia_pkg::HW_MASK_ALL
                     && global_int_enable && !exception_level_flag && !error_level_flag; // RULE8 RULE19
    assign sw_ok   = |sw_ready && global_int_enable && !exception_level_flag && !error_level_flag; // RULE3
    assign take_hw = ce && hw_ok;
    assign take_sw = ce && sw_ok && !hw_ok; // RULE4

    always_comb begin
        lvl_next                 = lvl_reg;
        src0_mode_next           = src0_mode_reg;
        status_next              = status_reg;
        soft_pending_bits_next   = soft_pending_bits_reg;
        shadow_set_disable_next  = shadow_set_disable_reg;
        current_shadow_set_next  = current_shadow_set_reg;
        previous_shadow_set_next = previous_shadow_set_reg;
        current_mask_level_next  = current_mask_level_reg;
        vector_register_next     = vector_register_reg;
        hold_next                = hold_reg && !vec_rd; // RULE19
        exception_return_pc_next = exception_return_pc_reg;
        pend_next                = pend_reg;
        dma_next                 = req_all & ~zero_lvl; // RULE13
        bvalid_next              = bvalid_reg && !s_axi_bready;
        bresp_next               = bresp_reg;
        rvalid_next              = rvalid_reg && !s_axi_rready;
        rresp_next               = rresp_reg;
        rdata_next               = rdata_reg;
        for (int b = 0; b < 2; b++) begin
            sw_age_next[b] = !soft_pending_bits_reg[b] ? 2'h0 :
                             sw_age_reg[b] == mia_pkg::SW_MIN_AGE ? sw_age_reg[b] : sw_age_reg[b] + 2'h1; // RULE2
        end
        if (wr_go) begin
            bvalid_next = 1'b1;
            bresp_next  = mia_pkg::RESP_OKAY;
            if (s_axi_awaddr[11:9] == mia_pkg::SRC_AREA && int'(wsrc) < NSRC) begin
                if (s_axi_wstrb[0]) begin
                    lvl_next[wsrc] = s_axi_wdata[mia_pkg::SC_LVL +: 3]; // RULE7
                    if (wsrc == '0) begin
                        src0_mode_next = s_axi_wdata[mia_pkg::SC_TRIG +: 2];
                    end
                end
            end else if (s_axi_awaddr == mia_pkg::OFF_STATUS) begin
                status_next = s_axi_wdata;
            end else if (s_axi_awaddr == mia_pkg::OFF_CAUSE) begin
                soft_pending_bits_next = s_axi_wdata[1:0]; // RULE1
            end else if (s_axi_awaddr == mia_pkg::OFF_SHADOW) begin
                shadow_set_disable_next  = s_axi_wdata[mia_pkg::SH_DISABLE];
                current_shadow_set_next  = s_axi_wdata[mia_pkg::SH_CUR +: 4];
                previous_shadow_set_next = s_axi_wdata[mia_pkg::SH_PREV +: 4];
            end else if (s_axi_awaddr == mia_pkg::OFF_LEVEL) begin
                // restoring the mask level is refused while an acceptance is held
                if (!hold_reg) begin
                    current_mask_level_next = s_axi_wdata[2:0];
                end
            end else if (s_axi_awaddr == mia_pkg::OFF_CLEAR) begin
                if (int'(s_axi_wdata[IW-1:0]) < NSRC) begin
                    pend_next[s_axi_wdata[IW-1:0]] = 1'b0; // RULE20
                end
            end else if (s_axi_awaddr != mia_pkg::OFF_VECTOR && s_axi_awaddr != mia_pkg::OFF_RET_PC) begin
                bresp_next = mia_pkg::RESP_DECERR;
            end
        end
        // set after clear: a request in the clearing cycle survives; repeats just re-set
        pend_next = pend_next | (req_all & ~zero_lvl); // RULE17 RULE18
        if (take_hw) begin
            status_next[mia_pkg::ST_EXC] = 1'b1; // RULE10
            current_mask_level_next      = best_lvl; // RULE10
            vector_register_next         = {best_idx, 2'b00}; // RULE14 RULE15 RULE16
            hold_next                    = 1'b1; // RULE19
            exception_return_pc_next     = core_pc;
            if (!shadow_set_disable_reg) begin
                previous_shadow_set_next = current_shadow_set_reg;
                current_shadow_set_next  = {1'b0, best_lvl}; // RULE11
            end
        end else if (take_sw) begin
            status_next[mia_pkg::ST_EXC] = 1'b1;
            exception_return_pc_next     = core_pc; // RULE2
            if (!shadow_set_disable_reg) begin
                previous_shadow_set_next = current_shadow_set_reg; // RULE5
            end
        end
        if (rd_go) begin
            rvalid_next = 1'b1;
            rresp_next  = mia_pkg::RESP_OKAY;
            rdata_next  = 32'h0;
            if (s_axi_araddr[11:9] == mia_pkg::SRC_AREA && int'(rsrc) < NSRC) begin
                rdata_next[mia_pkg::SC_LVL +: 3] = lvl_reg[rsrc];
                rdata_next[mia_pkg::SC_TRIG - 1] = pend_reg[rsrc];
                if (rsrc == '0) begin
                    rdata_next[mia_pkg::SC_TRIG +: 2] = src0_mode_reg;
                end
            end else begin
                case (s_axi_araddr)
                    mia_pkg::OFF_STATUS: rdata_next = status_reg;
                    mia_pkg::OFF_CAUSE:  rdata_next[1:0] = soft_pending_bits_reg;
                    mia_pkg::OFF_SHADOW: begin
                        rdata_next[mia_pkg::SH_DISABLE]   = shadow_set_disable_reg;
                        rdata_next[mia_pkg::SH_CUR +: 4]  = current_shadow_set_reg;
                        rdata_next[mia_pkg::SH_PREV +: 4] = previous_shadow_set_reg;
                    end
                    mia_pkg::OFF_LEVEL:  rdata_next[2:0] = current_mask_level_reg;
                    mia_pkg::OFF_VECTOR: rdata_next[8:0] = vector_register_reg;
                    mia_pkg::OFF_RET_PC: rdata_next = exception_return_pc_reg;
                    default:             rresp_next = mia_pkg::RESP_DECERR;
                endcase
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < NSRC; i++) begin
                lvl_reg[i] <= 3'h0;
            end
            sw_age_reg[0]           <= 2'h0;
            sw_age_reg[1]           <= 2'h0;
            pend_reg                <= '0;
            src0_mode_reg           <= 2'h0;
            status_reg              <= mia_pkg::RESET_STATUS;
            soft_pending_bits_reg   <= 2'h0;
            shadow_set_disable_reg  <= 1'b1;
            current_shadow_set_reg  <= 4'h0;
            previous_shadow_set_reg <= 4'h0;
            current_mask_level_reg  <= 3'h0;
            vector_register_reg     <= 9'h000;
            hold_reg                <= 1'b0;
            exception_return_pc_reg <= 32'h0;
            dma_reg                 <= '0;
            bvalid_reg              <= 1'b0;
            bresp_reg               <= 2'h0;
            rvalid_reg              <= 1'b0;
            rresp_reg               <= 2'h0;
            rdata_reg               <= 32'h0;
        end else if (ce) begin
            lvl_reg                 <= lvl_next;
            sw_age_reg              <= sw_age_next;
            pend_reg                <= pend_next;
            src0_mode_reg           <= src0_mode_next;
            status_reg              <= status_next;
            soft_pending_bits_reg   <= soft_pending_bits_next;
            shadow_set_disable_reg  <= shadow_set_disable_next;
            current_shadow_set_reg  <= current_shadow_set_next;
            previous_shadow_set_reg <= previous_shadow_set_next;
            current_mask_level_reg  <= current_mask_level_next;
            vector_register_reg     <= vector_register_next;
            hold_reg                <= hold_next;
            exception_return_pc_reg <= exception_return_pc_next;
            dma_reg                 <= dma_next;
            bvalid_reg              <= bvalid_next;
            bresp_reg               <= bresp_next;
            rvalid_reg              <= rvalid_next;
            rresp_reg               <= rresp_next;
            rdata_reg               <= rdata_next;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_sw_delay: assert property ($rose(soft_pending_bits_reg[0]) && !soft_pending_bits_reg[1]
        |-> !take_sw [*3]) else $error("software interrupt taken too early"); // RULE2
    chk_sw_enable: assert property (take_sw |-> global_int_enable && !exception_level_flag && !error_level_flag // RULE3
        && |(soft_pending_bits_reg & int_mask_bits[1:0])) else $error("software interrupt taken while disabled");
    chk_hw_first: assert property (take_hw |-> !take_sw) else $error("software beat hardware"); // RULE4
    chk_hw_enable: assert property (take_hw |-> int_mask_bits[4:2] == 3'h7 && global_int_enable // RULE8
        && !exception_level_flag && !error_level_flag) else $error("hardware interrupt taken while disabled");
    chk_accept_update: assert property (take_hw |=> exception_level_flag // RULE10
        && global_int_enable == $past(global_int_enable)
        && current_mask_level_reg == $past(best_lvl)) else $error("acceptance update wrong");
    chk_bank_switch: assert property (take_hw && !shadow_set_disable_reg
        |=> current_shadow_set_reg == {1'b0, $past(best_lvl)}) else $error("bank not switched"); // RULE11
    chk_sw_bank: assert property (take_sw && !shadow_set_disable_reg |=> $stable(current_shadow_set_reg)
        && previous_shadow_set_reg == current_shadow_set_reg) else $error("software bank update wrong"); // RULE5
    chk_nest_level: assert property (take_hw |-> best_lvl > current_mask_level_reg && best_lvl != 3'h0)
        else $error("level not above mask"); // RULE12
    chk_zero_latch: assert property ((pend_reg & zero_lvl) == '0 |=> (pend_reg & zero_lvl) == '0
        || $past(wr_go)) else $error("level zero request latched"); // RULE17
    chk_vec_code: assert property (take_hw |=> vector_register_reg == {$past(best_idx), 2'b00})
        else $error("vector code wrong"); // RULE14
    chk_hold_vec: assert property (hold_reg && !vec_rd |=> $stable(vector_register_reg)
        && $stable(current_mask_level_reg)) else $error("held vector changed"); // RULE19

    cov_hw: cover property (take_hw);
    cov_sw: cover property (take_sw);
    cov_both: cover property (hw_ok && sw_ok && ce);
    cov_nest: cover property (take_hw && current_mask_level_reg != 3'h0);
endmodule : mia_top

// ---- verilog/mia_pkg.sv ----
package mia_pkg;
    // register byte offsets
    localparam logic [11:0] OFF_STATUS  = 12'h000;
    localparam logic [11:0] OFF_CAUSE   = 12'h004;
    localparam logic [11:0] OFF_SHADOW  = 12'h008;
    localparam logic [11:0] OFF_LEVEL   = 12'h00c;
    localparam logic [11:0] OFF_VECTOR  = 12'h010;
    localparam logic [11:0] OFF_CLEAR   = 12'h014;
    localparam logic [11:0] OFF_RET_PC  = 12'h018;
    localparam logic [2:0]  SRC_AREA    = 3'h1;
    // status fields
    localparam int ST_ENABLE  = 0;
    localparam int ST_EXC     = 1;
    localparam int ST_ERR     = 2;
    localparam int ST_MASK    = 8;
    // shadow set control fields
    localparam int SH_DISABLE = 0;
    localparam int SH_CUR     = 4;
    localparam int SH_PREV    = 8;
    // source control fields
    localparam int SC_LVL  = 0;
    localparam int SC_TRIG = 4;
    localparam logic [1:0] TRIG_SOFT_SET = 2'h1;
    localparam logic [1:0] RESP_OKAY    = 2'h0;
    localparam logic [1:0] RESP_DECERR  = 2'h3;
    localparam logic [2:0] HW_MASK_ALL  = 3'h7;
    // software interrupt acceptance delay
    localparam logic [1:0] SW_MIN_AGE   = 2'h3;
    // named hardware sources
    localparam int SRC_MOTOR0_MATCH = 20;
    localparam int SRC_MOTOR0_EMG   = 22;
    localparam int SRC_MOTOR1_EMG   = 23;
    localparam int SRC_TIMER0_EMG   = 33;
    localparam logic [31:0] RESET_STATUS = 32'h0000_0004;
endpackage : mia_pkg

// ---- dv/mia_core_model.sv ----
`timescale 1ns/1ps
// stands in for the core and the peripherals: requests are one-cycle pulses,
// the pc steps every cycle so a late or early save shows up as a wrong value
module mia_core_model #(
    parameter int NSRC = 96
) (
    input  wire logic            aclk,
    input  wire logic            aresetn,
    input  wire logic            go,
    input  wire logic [NSRC-1:0] sel,
    input  wire logic            take_hw,
    input  wire logic            take_sw,
    output logic [NSRC-1:0]      irq_req,
    output logic [31:0]          core_pc,
    output logic [31:0]          saved_pc
);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_req  <= '0;
            core_pc  <= 32'h0000_1000;
            saved_pc <= 32'h0;
        end else begin
            irq_req <= go ? sel : '0;
            core_pc <= core_pc + 32'h4;
            if (take_hw || take_sw) begin
                saved_pc <= core_pc;
            end
        end
    end
endmodule : mia_core_model

// ---- dv/mia_top_test.sv ----
`timescale 1ns/1ps
module mia_top_test;
    localparam int NSRC = 96;
    logic            aclk, aresetn, ce, go, take_hw, take_sw;
    logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic            s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [11:0]     s_axi_awaddr, s_axi_araddr;
    logic [31:0]     s_axi_wdata, s_axi_rdata, core_pc, saved_pc, rd;
    logic [3:0]      s_axi_wstrb, active_bank, nm;
    logic [1:0]      s_axi_bresp, s_axi_rresp, rs;
    logic [NSRC-1:0] irq_req, dma_trigger, sel;
    int              n_errors, tests_run, t0, a, b, la, lb, w, lw;
    int              srcs[5] = '{20, 22, 23, 33, 0};

    mia_top #(.NSRC(NSRC)) mia_top_i (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .irq_req, .motor0_count_match_int(nm[0]), .motor0_emergency_int(nm[1]), .motor1_emergency_int(nm[2]),
        .timer0_emergency_int(nm[3]), .core_pc, .take_hw, .take_sw, .active_bank, .dma_trigger);
    mia_core_model #(.NSRC(NSRC)) mia_core_model_i (.aclk, .aresetn, .go, .sel, .take_hw, .take_sw, .irq_req,
        .core_pc, .saved_pc);

    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    // ready is combinational, so it is judged at the falling edge and taken at the next rising one
    task automatic axw(input logic [11:0] ad, input logic [31:0] d);
        @(posedge aclk);
        s_axi_awaddr  <= ad;
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        do @(negedge aclk); while (s_axi_awready !== 1'b1);
        @(posedge aclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
        rs = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : axw

    task automatic axr(input logic [11:0] ad);
        @(posedge aclk);
        s_axi_araddr  <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        do @(negedge aclk); while (s_axi_arready !== 1'b1);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
        rd = s_axi_rdata;
        rs = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : axr

    task automatic fire(input logic [NSRC-1:0] m, input logic [3:0] n);
        @(posedge aclk);
        go  <= 1'b1;
        sel <= m;
        nm  <= n;
        @(posedge aclk);
        go <= 1'b0;
        nm <= 4'h0;
    endtask : fire

    task automatic wait_take(input bit sw);
        do @(negedge aclk); while ((sw ? take_sw : take_hw) !== 1'b1);
    endtask : wait_take

    // the vector read releases the hold; nesting is reopened while the mask level still
    // holds the accepted level, so pending sources of that level or lower must stay out
    task automatic retire(input int x, input int y, input int vec);
        axr(mia_pkg::OFF_VECTOR);
        chk("vector", 32'(vec), rd);
        axw(mia_pkg::OFF_STATUS, 32'h0000_1f01);
        axr(mia_pkg::OFF_STATUS);
        chk("nested status", 32'h0000_1f01, rd);
        axw(mia_pkg::OFF_CLEAR, 32'(x));
        axw(mia_pkg::OFF_CLEAR, 32'(y));
        axw(mia_pkg::OFF_LEVEL, 32'h0);
    endtask : retire

    task automatic results();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results

    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        results();
    end

    initial begin
        {go, nm, sel, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
        ce = 1'b1;
        s_axi_wstrb = 4'hf;
        aresetn = 1'b0;
        w = $urandom(87340);
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        axr(mia_pkg::OFF_STATUS);
        chk("status", mia_pkg::RESET_STATUS, rd);
        axr(mia_pkg::OFF_SHADOW);
        chk("shadow", 32'h1, rd);
        axr(12'hffc);
        chk("resp", 32'(mia_pkg::RESP_DECERR), 32'(rs));
        fire(96'h20, 4'h0);
        axr(12'h214);
        chk("pending", 32'h0, {31'h0, rd[3]});
        $display("test reset done");
        axw(mia_pkg::OFF_STATUS, 32'h0000_1f01);
        axw(mia_pkg::OFF_SHADOW, 32'h0);
        for (int i = 0; i < 8; i++) begin
            a = 1 + $urandom % 46;
            b = 1 + (a + $urandom % 45) % 46;
            la = 1 + $urandom % 7;
            lb = (i < 3) ? la : 1 + $urandom % 7;
            w = (la > lb || (la == lb && a < b)) ? a : b;
            lw = (w == a) ? la : lb;
            axw(12'h200 + 12'(4 * a), 32'(la));
            axw(12'h200 + 12'(4 * b), 32'(lb));
            fire((96'h1 << a) | (96'h1 << b), 4'h0);
            wait_take(1'b0);
            chk("dma", 32'h3, {30'h0, dma_trigger[a], dma_trigger[b]});
            axw(mia_pkg::OFF_LEVEL, 32'h0);
            axr(mia_pkg::OFF_LEVEL);
            chk("level", 32'(lw), rd);
            axr(mia_pkg::OFF_STATUS);
            chk("status", 32'h0000_1f03, rd);
            chk("bank", 32'(lw), {28'h0, active_bank});
            axr(12'h200 + 12'(4 * (a + b - w)));
            chk("loser pending", 32'h1, {31'h0, rd[3]});
            retire(a, b, 4 * w);
        end
        $display("test arbitration done");
        for (int i = 0; i < 5; i++) begin
            w = srcs[i];
            if (w == 0) begin
                // the level must stand before the set request: a level-zero source latches nothing
                axw(12'h200, 32'h3);
                axw(12'h200, 32'h13);
            end else begin
                axw(12'h200 + 12'(4 * w), 32'h4);
                fire('0, 4'(1 << i));
                wait_take(1'b0);
            end
            axr(mia_pkg::OFF_STATUS);
            chk("status", 32'h0000_1f03, rd);
            retire(w, w, 4 * w);
        end
        $display("test named sources done");
        axr(mia_pkg::OFF_SHADOW);
        lw = rd[7:4];
        axw(mia_pkg::OFF_CAUSE, 32'h1);
        t0 = $time;
        wait_take(1'b1);
        // t0 is one cycle after the pending edge; three cycles later plus half a period
        chk("sw delay", 32'h1, 32'($time - t0 >= 25));
        axr(mia_pkg::OFF_RET_PC);
        chk("ret pc", saved_pc, rd);
        axr(mia_pkg::OFF_SHADOW);
        chk("shadow", {20'h0, 4'(lw), 4'(lw), 4'h0}, rd);
        chk("bank", 32'(lw), {28'h0, active_bank});
        axw(mia_pkg::OFF_CAUSE, 32'h2);
        axw(mia_pkg::OFF_STATUS, 32'h0000_1d01);
        t0 = 0;
        repeat (10) begin
            @(negedge aclk);
            if (take_sw !== 1'b0) t0++;
        end
        chk("masked take", 32'h0, 32'(t0));
        axr(mia_pkg::OFF_STATUS);
        chk("masked status", 32'h0000_1d01, rd);
        $display("test software done");
        results();
    end
endmodule : mia_top_test
